// file: rtl/segment_decode_op.sv
`timescale 1ns/10ps
// Summary of operation
// [RULE_01] Convert selected hex digits of source word.
// [RULE_02] Successive digits ascend, wrapping 3 to 0.
// [RULE_03] Codes fill bytes upward into higher words.
// [RULE_04] Untouched byte of a word is kept.
// [RULE_05] Error flag on bad designator, else clear.
// [RULE_06] Segments a-g in bits 0-6, bit7 zero.
// [RULE_07] Digits 0-7 map to documented codes.
// [RULE_08] Digits 8-F map to documented codes.
// [RULE_09] First code lands in selected byte half.
// [RULE_10] Designator: first, count-1, byte select fields.
// [RULE_11] Start pulse; bytes and done within four clocks.

// A request is taken on the clock edge that sees i_start high, with the source word
// and the designator valid on that same edge. The answer stands one clock later:
// o_done and o_dest_byte_we pulse for that single clock, while o_dest_data and
// o_error_flag hold until the next request. Requests may follow on every clock.
//
// The block stores no destination words itself. The requester must apply each
// enabled byte to its own storage on the clock that the enable is high; a byte
// whose enable stays low must be left as it was.
module segment_decode_op #(
   // Digit lanes; the source word always carries exactly this many hex digits.
   parameter int NUM_LANES = seg_decode_pkg::NUM_DIGITS,
   // Byte slots across all destination words.
   parameter int NUM_SLOTS = seg_decode_pkg::DEST_WORDS * seg_decode_pkg::BYTES_PER_WORD
) (
   // Clock and reset
   input  wire logic                                                             i_mclk,
   input  wire logic                                                             i_rst_n,
   // Request
   input  wire logic                                                             i_start,
   input  wire logic [seg_decode_pkg::SRC_W-1:0]                                 i_source,
   input  wire logic [seg_decode_pkg::DESIG_W-1:0]                               i_digit_designator,
   // Result words with per-byte write enables, word 0 is the first destination word
   output logic      [seg_decode_pkg::DEST_WORDS*seg_decode_pkg::WORD_W-1:0]     o_dest_data,
   output logic      [seg_decode_pkg::DEST_WORDS*seg_decode_pkg::BYTES_PER_WORD-1:0] o_dest_byte_we,
   // Completion and status
   output logic                                                                  o_done,
   output logic                                                                  o_error_flag
);
   import seg_decode_pkg::*;

   // A digit position wraps inside POS_W bits, which is what rolls the top digit over to digit 0.
   localparam int POS_W  = $clog2(NUM_LANES);
   localparam int SLOT_W = $clog2(NUM_SLOTS);
   localparam int DATA_W = NUM_SLOTS * BYTE_W;

   // Lanes and slots are tied to fixed port widths, so other values are refused outright.
   generate
      if (NUM_LANES != NUM_DIGITS) begin : g_bad_lanes
         $error("NUM_LANES must equal the number of digits in the source word.");
      end
      if ((NUM_LANES & (NUM_LANES - 1)) != 0) begin : g_bad_pow2
         $error("NUM_LANES must be a power of two for the digit position to wrap.");
      end
      if (NUM_SLOTS != DEST_WORDS * BYTES_PER_WORD) begin : g_bad_slots
         $error("NUM_SLOTS must equal the byte count of the destination words.");
      end
      if (NUM_SLOTS < NUM_LANES + 1) begin : g_short_slots
         $error("NUM_SLOTS must leave room for every lane after an upper-byte start.");
      end
      if (DATA_W != DEST_WORDS * WORD_W) begin : g_bad_data
         $error("The byte slots must fill the destination words exactly.");
      end
      if (FIELD_W < POS_W + 1) begin : g_narrow_field
         $error("FIELD_W is too narrow for the digit position and count fields.");
      end
      if (FIELD_MAX_DIGIT != FIELD_W'(NUM_LANES - 1)) begin : g_bad_max_digit
         $error("FIELD_MAX_DIGIT must name the top digit lane.");
      end
      if (FIELD_MAX_SEL != FIELD_W'(BYTES_PER_WORD - 1)) begin : g_bad_max_sel
         $error("FIELD_MAX_SEL must name the upper byte of a word.");
      end
      if (BYTE_W != $bits(hex_to_seg(4'h0)) + 1) begin : g_bad_code
         $error("BYTE_W must hold the segment bits plus the spare top bit.");
      end
   endgenerate

   // Reset enters asynchronously but leaves on the clock through two flip-flops.
   // Without this, a release close to an edge could let some output flops leave reset a clock
   // before others.
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // Designator fields; the spare nibble on top must stay clear.
   wire [FIELD_W-1:0] first_digit;
   wire [FIELD_W-1:0] count_m1;
   wire [FIELD_W-1:0] byte_sel;
   wire               first_bad;
   wire               count_bad;
   wire               sel_bad;
   wire               spare_bad;
   wire               desig_bad;
   wire               accept_ok;

   assign first_digit = i_digit_designator[FIRST_LSB +: FIELD_W];                 // see [RULE_10]
   assign count_m1    = i_digit_designator[COUNT_LSB +: FIELD_W];                 // see [RULE_10]
   assign byte_sel    = i_digit_designator[BYTESEL_LSB +: FIELD_W];               // see [RULE_10]
   assign first_bad   = first_digit > FIELD_MAX_DIGIT;                            // see [RULE_05]
   assign count_bad   = count_m1 > FIELD_MAX_DIGIT;                               // see [RULE_05]
   assign sel_bad     = byte_sel > FIELD_MAX_SEL;                                 // see [RULE_05]
   assign spare_bad   = (i_digit_designator & DESIG_SPARE_MASK) != '0;            // see [RULE_05]
   assign desig_bad   = first_bad || count_bad || sel_bad || spare_bad;
   assign accept_ok   = i_start && !desig_bad;

   // Per-lane results. Lane k carries the k-th digit of the run whether or not the count
   // reaches it; lane_used decides later whether it is written.
   wire [NUM_LANES-1:0][BYTE_W-1:0] lane_code;
   wire [NUM_LANES-1:0][SLOT_W-1:0] lane_slot;
   wire [NUM_LANES-1:0]             lane_used;

   for (genvar k = 0; k < NUM_LANES; k++) begin : g_lane
      wire [POS_W-1:0]    pos;
      wire [DIGIT_W-1:0]  nibble;
      wire [BYTE_W-2:0]   segs;

      // The sum is kept to POS_W bits on purpose so that the top digit is followed by digit 0.
      assign pos          = first_digit[POS_W-1:0] + POS_W'(k);                   // see [RULE_02]
      assign nibble       = i_source[pos*DIGIT_W +: DIGIT_W];                     // see [RULE_01]
      assign segs         = hex_to_seg(nibble);                                   // see [RULE_07] see [RULE_08]
      assign lane_code[k] = {SEG_TOP_BIT, segs};                                  // see [RULE_06]
      assign lane_used[k] = FIELD_W'(k) <= count_m1;                              // see [RULE_01]
      // The first lane lands in the selected half of word 0 and later lanes climb from there.
      assign lane_slot[k] = SLOT_W'(byte_sel[0]) + SLOT_W'(k);                    // see [RULE_03] see [RULE_09]
   end

   // Each slot collects the one lane, if any, that points at it.
   // A slot that no lane reaches keeps a low enable, so the requester's copy of that byte survives.
   wire [NUM_SLOTS-1:0][BYTE_W-1:0] slot_code;
   wire [NUM_SLOTS-1:0]             slot_hit;

   for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
      wire  [NUM_LANES-1:0] lane_hit;
      logic [BYTE_W-1:0]    merged;

      for (genvar k = 0; k < NUM_LANES; k++) begin : g_match
         assign lane_hit[k] = lane_used[k] && (lane_slot[k] == SLOT_W'(s));
      end

      // At most one lane hits a slot, so an OR of the masked codes is a clean select.
      always_comb begin
         merged = '0;
         for (int k = 0; k < NUM_LANES; k++) begin
            if (lane_hit[k]) begin
               merged = merged | lane_code[k];
            end
         end
      end

      assign slot_code[s] = merged;
      assign slot_hit[s]  = |lane_hit;                                            // see [RULE_04]
   end

   // What is loaded on an accepted or a refused request.
   wire [DATA_W-1:0]    load_data;
   wire [NUM_SLOTS-1:0] load_we;

   assign load_data = desig_bad ? '0 : slot_code;
   assign load_we   = accept_ok ? slot_hit : '0;                                  // see [RULE_04] see [RULE_05]

   // Done answers every request one clock later, refused ones included, so the
   // requester never has to time out on a bad designator.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_done <= 1'b0;
      end else begin
         o_done <= i_start;                                                       // see [RULE_11]
      end
   end

   // Enables stand for one clock only, so a stored result is never written twice
   // when requests pause.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_dest_byte_we <= '0;
      end else begin
         o_dest_byte_we <= load_we;                                               // see [RULE_11]
      end
   end

   // Data stands until the next request; a refused request clears it rather than
   // leave codes of an earlier request that could be mistaken for fresh ones.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_dest_data <= '0;
      end else if (i_start) begin
         o_dest_data <= load_data;                                                // see [RULE_03]
      end
   end

   // The flag follows every request: set on a refused designator, cleared on a good one.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_error_flag <= 1'b0;
      end else if (i_start) begin
         o_error_flag <= desig_bad;                                               // see [RULE_05]
      end
   end
endmodule : segment_decode_op

// file: shared/seg_decode_pkg.sv
package seg_decode_pkg;
   localparam int          SRC_W       = 16;
   localparam int          DIGIT_W     = 4;
   localparam int          NUM_DIGITS  = 4;
   localparam int          BYTE_W      = 8;
   localparam int          DESIG_W     = 16;
   localparam int          WORD_W      = 16;
   localparam int          BYTES_PER_WORD = 2;
   // Designator fields.
   localparam int          FIRST_LSB   = 0;
   localparam int          COUNT_LSB   = 4;
   localparam int          BYTESEL_LSB = 8;
   localparam int          FIELD_W     = 4;
   localparam logic [3:0]  FIELD_MAX_DIGIT = 4'h3;
   localparam logic [3:0]  FIELD_MAX_SEL   = 4'h1;
   localparam logic [15:0] DESIG_SPARE_MASK = 16'hf000;
   // Four codes that start in an upper byte spread over three destination words.
   localparam int          DEST_WORDS  = 3;
   localparam int          DEST_IDX_W  = 2;
   localparam logic        SEG_TOP_BIT = 1'b0;

   function automatic logic [6:0] hex_to_seg(input logic [3:0] d);
      logic [6:0] s;
      s = 7'h00;
      case (d)
         4'h0: s = 7'h3f;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5b;
         4'h3: s = 7'h4f;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6d;
         4'h6: s = 7'h7d;
         4'h7: s = 7'h27;
         4'h8: s = 7'h7f;
         4'h9: s = 7'h6f;
         4'ha: s = 7'h77;
         4'hb: s = 7'h7c;
         4'hc: s = 7'h39;
         4'hd: s = 7'h5e;
         4'he: s = 7'h79;
         default: s = 7'h71;
      endcase
      return s;
   endfunction : hex_to_seg
endpackage : seg_decode_pkg

// file: verification/seg_decode_chk.sv
`timescale 1ns/10ps
module seg_decode_chk (
   input wire logic        i_mclk, i_rst_n, i_start, o_done, o_error_flag,
   input wire logic [15:0] i_source, i_digit_designator,
   input wire logic [47:0] o_dest_data,
   input wire logic [5:0]  o_dest_byte_we
);
   wire ok = i_digit_designator[15:8] <= 8'h01 && i_digit_designator[7:4] <= 4'h3 && i_digit_designator[3:0] <= 4'h3;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   AST_DONE: assert property (i_start |=> o_done) else $error("no done");
   AST_QUIET: assert property (!i_start |=> !o_done && o_dest_byte_we == 6'h00) else $error("stray");
   AST_BAD: assert property (i_start && !ok |=> o_error_flag && o_dest_byte_we == 6'h00) else $error("bad");
   AST_GOOD: assert property (i_start && ok |=> !o_error_flag) else $error("good");
   AST_HOLD: assert property (!i_start |=> $stable(o_error_flag)) else $error("flag");
   AST_CNT: assert property (i_start && ok |=> $countones(o_dest_byte_we) == $past(i_digit_designator[7:4]) + 1)
      else $error("count");
   AST_FIRST: assert property (i_start && ok |=> o_dest_byte_we[$past(i_digit_designator[8])]) else $error("slot");
   AST_TOP: assert property (o_done |-> (o_dest_data & 48'h808080808080) == 48'h0) else $error("bit7");
endmodule : seg_decode_chk

// file: verification/seg_requester.sv
`timescale 1ns/10ps
module seg_requester (
   input  wire logic        i_mclk,
   input  wire logic [47:0] i_data,
   input  wire logic [5:0]  i_we,
   output logic      [47:0] o_words
);
   initial o_words = 48'hcccccccccccc;
   // Only enabled bytes land, so a half-written word keeps its other byte.
   always @(posedge i_mclk) for (int s = 0; s < 6; s++) if (i_we[s]) o_words[8*s +: 8] <= i_data[8*s +: 8];
endmodule : seg_requester

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, o_done, o_error_flag;
   logic [15:0] i_source = 16'h0000, i_digit_designator = 16'h0000;
   logic [47:0] o_dest_data, words;
   logic [5:0]  o_dest_byte_we;
   int          num_errors = 0, checks = 0;
   logic [7:0]  seg [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
                            8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
   always #2.5 i_mclk = ~i_mclk;
   segment_decode_op dut (.i_mclk, .i_rst_n, .i_start, .i_source, .i_digit_designator, .o_dest_data,
                          .o_dest_byte_we, .o_done, .o_error_flag);
   seg_requester peer (.i_mclk(i_mclk), .i_data(o_dest_data), .i_we(o_dest_byte_we), .o_words(words));
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   task automatic conv(input logic [15:0] src, input logic [15:0] d, input logic bad);
      logic [47:0] e, mk;
      logic [5:0]  m;
      e = '0; mk = '0; m = '0;
      for (int k = 0; k <= d[7:4] && !bad; k++) begin
         m[d[8] + k] = 1'b1;
         mk[8*(d[8]+k) +: 8] = 8'hff;
         e[8*(d[8]+k) +: 8] = seg[src[4*((d[3:0]+k)%4) +: 4]];
      end
      @(posedge i_mclk);
      {i_start, i_source, i_digit_designator} <= {1'b1, src, d};
      @(posedge i_mclk);
      i_start <= 1'b0;
      #1;
      check(o_done, 1'b1);
      check(o_error_flag, bad);
      check(o_dest_byte_we, m);
      check(o_dest_data & mk, e);
   endtask : conv
   task automatic s_codes;
      for (int i = 0; i < 4; i++) conv({4'(4*i+3), 4'(4*i+2), 4'(4*i+1), 4'(4*i)}, 16'h0030, 1'b0);
   endtask : s_codes
   task automatic s_paths;
      conv(16'h1234, 16'h0121, 1'b0);
      conv(16'hfa5c, 16'h0123, 1'b0);
   endtask : s_paths
   task automatic s_merge;
      conv(16'h0008, 16'h0000, 1'b0);
      conv(16'h0001, 16'h0100, 1'b0);
      @(posedge i_mclk);
      #1;
      check(words[15:0], 16'h067f);
   endtask : s_merge
   task automatic s_bad;
      conv(16'h1234, 16'h1000, 1'b1);
      conv(16'h1234, 16'h0200, 1'b1);
      conv(16'h1234, 16'h0040, 1'b1);
      conv(16'h1234, 16'h0004, 1'b1);
   endtask : s_bad
   initial begin
      repeat (16) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      s_codes();
      s_paths();
      s_bad();
      s_merge();
      give_verdict();
   end
   initial begin
      #5000;
      num_errors++;
      give_verdict();
   end
endmodule : tb_top
bind segment_decode_op seg_decode_chk chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start), .o_done(o_done),
   .o_error_flag(o_error_flag), .i_source(i_source), .i_digit_designator(i_digit_designator),
   .o_dest_data(o_dest_data), .o_dest_byte_we(o_dest_byte_we));
